/* common/rad_consts.svh */
/*
 Register offsets, reset values, limit defaults, gain codes and scheme codes of the receive gain and demodulation control.
 Assumes a 32-bit AHB-Lite register bus and a 100 MHz core clock.
*/
`ifndef RAD_CONSTS_SVH
`define RAD_CONSTS_SVH
`define RAD_OFF_CTRL 8'h00
`define RAD_OFF_LIMIT 8'h04
`define RAD_OFF_CLKDIV 8'h08
`define RAD_OFF_DEMOD 8'h0C
`define RAD_OFF_STATUS 8'h10
`define RAD_OFF_FREQ 8'h14
`define RAD_CTRL_RESET 32'h00E00005
`define RAD_LIMIT_RESET 32'h000231E0
`define RAD_CLKDIV_RESET 32'h28000010
`define RAD_DEMOD_RESET 32'h10004100
`define RAD_LOWER_DEFAULT 7'h1E
`define RAD_UPPER_DEFAULT 7'h46
`define RAD_GAIN_LAST 3'h4
`define RAD_GAIN_HIGH 2'h2
`define RAD_GAIN_MED 2'h1
`define RAD_GAIN_LOW 2'h0
`define RAD_SCHEME_LINEAR 3'h0
`define RAD_SCHEME_FSK3 3'h2
`endif

/* common/rad_pkg.sv */
/*
 Types of the receive gain and demodulation control.
 Assumes the constants header is compiled alongside.
*/
package rad_pkg;
  typedef enum logic [1:0] {
    RAD_IDLE = 2'b00,
    RAD_EVAL = 2'b01,
    RAD_SETTLE = 2'b11
  } rad_state_t;

  typedef struct packed {
    logic [1:0] amp;
    logic [1:0] filt;
  } rad_gain_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } rad_ahb_req_t;
endpackage : rad_pkg

/* hw/rad_rx_ctrl.sv */
/*
 Receive gain loop, offset clock divider, demodulator path, post filter, slicer and clock recovery with AHB-Lite registers.
 Assumes strength, correlator and discriminator inputs come from on-chip logic on core_clk.
*/
// Decided for this implementation: the register offsets and the AHB-Lite register port.
//
// Overview of operation
// - Strength above upper limit lowers gain one step.
// - Strength below lower limit raises gain one step.
// - Limits reset to 30 and 70.
// - Six-bit divider sets settling delay between steps.
// - Offset clock is core clock over 4/8/16/32.
// - Gain loop on by default, can be disabled.
// - Wait settling interval after every gain change.
// - Update rate is sequencer clock over step divider.
// - Loop has five gain settings.
// - Fixed modes use amp mode, gain, mixer bits.
// - Strength code sits in readback bits 7:1.
// - Readback also returns amp and filter gains.
// - Linear path enabled while frequency tracking runs.
// - Two-level correlator compares two correlator magnitudes.
// - Slice 2-level by sign; 3-level slicer or Viterbi.
// - Envelope gives linear-scheme slicing reference and frequency estimate.
// - Second-order low-pass with ten-bit bandwidth field.
// - Clock recovery drives retimed data and clock.
// - Filter gain from register when loop disabled.
`timescale 1ns/100ps
`default_nettype none
`include "rad_consts.svh"

module rad_rx_ctrl (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [6:0] strength_code,
  input wire logic [7:0] corr_mag_low,
  input wire logic [7:0] corr_mag_high,
  input wire logic [7:0] disc_freq,
  output logic [1:0] front_amp_gain,
  output logic [1:0] filter_gain,
  output logic front_amp_mode,
  output logic mixer_linearity,
  output logic linear_path_en,
  output logic offset_correction_clock,
  output logic serial_data_pin,
  output logic serial_clock_pin
);
  logic [31:0] ctrl_q;
  logic [31:0] limit_q;
  logic [31:0] clkdiv_q;
  logic [31:0] demod_q;
  rad_pkg::rad_ahb_req_t req_q;
  logic [31:0] rdata_q;
  rad_pkg::rad_state_t state_q;
  logic [2:0] gain_idx_q;
  logic [7:0] seq_cnt_q;
  logic [5:0] step_cnt_q;
  logic [6:0] strength_q;
  rad_pkg::rad_gain_t gain_out_q;
  logic [4:0] off_cnt_q;
  logic off_clk_q;
  logic signed [15:0] filt1_q;
  logic signed [15:0] filt2_q;
  logic signed [15:0] env_q;
  logic signed [16:0] prev_slice_q;
  logic [7:0] cdr_cnt_q;
  logic [4:0] phase_q;
  logic last_bit_q;
  logic sample_q;
  logic sdata_q;
  logic sclk_q;

  // Register fields.
  wire agc_en = ctrl_q[0];
  wire afc_en = ctrl_q[1];
  wire [2:0] scheme = ctrl_q[4:2];
  wire viterbi_en = ctrl_q[5];
  wire [1:0] fixed_amp_gain = ctrl_q[21:20];
  wire [1:0] fixed_filt_gain = ctrl_q[23:22];
  wire [6:0] lower_limit = limit_q[10:4];
  wire [6:0] upper_limit = limit_q[17:11];
  wire [1:0] offset_clock_divisor = clkdiv_q[5:4];
  wire [7:0] sequencer_clock_divisor = clkdiv_q[25:18];
  wire [5:0] gain_step_divider = clkdiv_q[31:26];
  wire [6:0] slicer_thr = demod_q[10:4];
  wire [7:0] cdr_divider = demod_q[19:12];
  wire [9:0] post_filter_bandwidth = demod_q[29:20];

  // Bus decode.
  wire addr_phase = hsel & hready & htrans[1];
  wire [7:0] rd_addr = haddr[7:0];
  wire wr_en = req_q.valid & req_q.write;
  wire wr_ctrl = wr_en & (req_q.addr == `RAD_OFF_CTRL);
  wire wr_limit = wr_en & (req_q.addr == `RAD_OFF_LIMIT);
  wire wr_clkdiv = wr_en & (req_q.addr == `RAD_OFF_CLKDIV);
  wire wr_demod = wr_en & (req_q.addr == `RAD_OFF_DEMOD);
  wire settling = state_q == rad_pkg::RAD_SETTLE;
  wire [31:0] status_word = {19'h0, settling, gain_out_q.amp, gain_out_q.filt, strength_q, 1'b0};
  wire [31:0] freq_word = {{16{env_q[15]}}, env_q};
  wire [31:0] rd_word = (rd_addr == `RAD_OFF_CTRL) ? ctrl_q :
                        (rd_addr == `RAD_OFF_LIMIT) ? limit_q :
                        (rd_addr == `RAD_OFF_CLKDIV) ? clkdiv_q :
                        (rd_addr == `RAD_OFF_DEMOD) ? demod_q :
                        (rd_addr == `RAD_OFF_STATUS) ? status_word :
                        (rd_addr == `RAD_OFF_FREQ) ? freq_word : 32'h0;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      req_q <= '0;
      rdata_q <= 32'h0;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      req_q <= '{valid: addr_phase, write: hwrite, addr: haddr[7:0]};
      rdata_q <= (addr_phase & ~hwrite) ? rd_word : 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl_q <= `RAD_CTRL_RESET;
      limit_q <= `RAD_LIMIT_RESET;
      clkdiv_q <= `RAD_CLKDIV_RESET;
      demod_q <= `RAD_DEMOD_RESET;
    end else begin
      if (wr_ctrl) ctrl_q <= hwdata;
      if (wr_limit) limit_q <= hwdata;
      if (wr_clkdiv) clkdiv_q <= hwdata;
      if (wr_demod) demod_q <= hwdata;
    end
  end

  assign hrdata = rdata_q;

  // Sequencer tick and gain update tick.
  wire seq_tick = (seq_cnt_q + 8'h01 >= sequencer_clock_divisor);
  wire step_done = seq_tick & ({2'h0, step_cnt_q} + 8'h01 >= {2'h0, gain_step_divider});
  wire above = strength_q > upper_limit;
  wire below = strength_q < lower_limit;
  wire step_down = above & (gain_idx_q != `RAD_GAIN_LAST);
  wire step_up = below & (gain_idx_q != 3'h0);

  rad_pkg::rad_state_t state_d;
  always_comb begin
    state_d = state_q;
    case (state_q)
      rad_pkg::RAD_IDLE: begin
        if (agc_en & step_done) state_d = rad_pkg::RAD_EVAL;
      end
      rad_pkg::RAD_EVAL: begin
        state_d = (step_down | step_up) ? rad_pkg::RAD_SETTLE : rad_pkg::RAD_IDLE;
      end
      rad_pkg::RAD_SETTLE: begin
        if (step_done) state_d = rad_pkg::RAD_IDLE;
      end
      default: state_d = rad_pkg::RAD_IDLE;
    endcase
    if (!agc_en) state_d = rad_pkg::RAD_IDLE;
  end

  // Five settings: high/high, med/high, med/med, med/low, low/low.
  rad_pkg::rad_gain_t agc_gain;
  always_comb begin
    case (gain_idx_q)
      3'h0: agc_gain = '{amp: `RAD_GAIN_HIGH, filt: `RAD_GAIN_HIGH};
      3'h1: agc_gain = '{amp: `RAD_GAIN_MED, filt: `RAD_GAIN_HIGH};
      3'h2: agc_gain = '{amp: `RAD_GAIN_MED, filt: `RAD_GAIN_MED};
      3'h3: agc_gain = '{amp: `RAD_GAIN_MED, filt: `RAD_GAIN_LOW};
      default: agc_gain = '{amp: `RAD_GAIN_LOW, filt: `RAD_GAIN_LOW};
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_q <= rad_pkg::RAD_IDLE;
      gain_idx_q <= 3'h0;
      seq_cnt_q <= 8'h00;
      step_cnt_q <= 6'h00;
      strength_q <= 7'h00;
      gain_out_q <= '{amp: `RAD_GAIN_HIGH, filt: `RAD_GAIN_HIGH};
    end else begin
      state_q <= state_d;
      strength_q <= strength_code;
      seq_cnt_q <= seq_tick ? 8'h00 : seq_cnt_q + 8'h01;
      if (state_q == rad_pkg::RAD_EVAL) step_cnt_q <= 6'h00;
      else if (step_done) step_cnt_q <= 6'h00;
      else if (seq_tick) step_cnt_q <= step_cnt_q + 6'h01;
      if (state_q == rad_pkg::RAD_EVAL && agc_en) begin
        if (step_down) gain_idx_q <= gain_idx_q + 3'h1;
        else if (step_up) gain_idx_q <= gain_idx_q - 3'h1;
      end
      gain_out_q <= agc_en ? agc_gain : '{amp: fixed_amp_gain, filt: fixed_filt_gain};
    end
  end

  assign front_amp_gain = gain_out_q.amp;
  assign filter_gain = gain_out_q.filt;

  // Offset correction clock: period 4 << select.
  wire [4:0] off_cnt_d = off_cnt_q + 5'h01;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      off_cnt_q <= 5'h00;
      off_clk_q <= 1'b0;
      front_amp_mode <= 1'b0;
      mixer_linearity <= 1'b0;
      linear_path_en <= 1'b0;
    end else begin
      off_cnt_q <= off_cnt_d;
      off_clk_q <= off_cnt_d[{1'b0, offset_clock_divisor} + 3'h1];
      front_amp_mode <= ctrl_q[25];
      mixer_linearity <= ctrl_q[28];
      linear_path_en <= afc_en | (scheme == `RAD_SCHEME_LINEAR);
    end
  end

  assign offset_correction_clock = off_clk_q;

  // Demodulator input and second-order post filter.
  wire use_linear = scheme == `RAD_SCHEME_LINEAR;
  wire signed [8:0] corr_diff = $signed({1'b0, corr_mag_high}) - $signed({1'b0, corr_mag_low});
  wire signed [8:0] demod_raw = use_linear ? $signed({disc_freq[7], disc_freq}) : corr_diff;
  wire signed [15:0] filt_in = {demod_raw[8], demod_raw[8], demod_raw, 5'h00};
  wire signed [10:0] bw_coef = $signed({1'b0, post_filter_bandwidth});
  wire signed [16:0] diff1 = {filt_in[15], filt_in} - {filt1_q[15], filt1_q};
  wire signed [16:0] diff2 = {filt1_q[15], filt1_q} - {filt2_q[15], filt2_q};
  wire signed [27:0] prod1 = diff1 * bw_coef;
  wire signed [27:0] prod2 = diff2 * bw_coef;
  wire signed [16:0] env_diff = {filt2_q[15], filt2_q} - {env_q[15], env_q};

  // Slicer.
  wire signed [15:0] slice_ref = use_linear ? env_q : 16'sh0000;
  wire signed [16:0] slice_val = {filt2_q[15], filt2_q} - {slice_ref[15], slice_ref};
  wire [16:0] slice_mag = slice_val[16] ? 17'(-slice_val) : slice_val;
  wire [16:0] thr_ext = {4'h0, slicer_thr, 6'h00};
  wire signed [17:0] pair_sum = {slice_val[16], slice_val} + {prev_slice_q[16], prev_slice_q};
  wire [17:0] pair_mag = pair_sum[17] ? 18'(-pair_sum) : pair_sum;
  wire three_level = scheme == `RAD_SCHEME_FSK3;
  wire bit_3slice = slice_mag > thr_ext;
  wire bit_3pair = pair_mag > {thr_ext, 1'b0};
  wire rx_bit = three_level ? (viterbi_en ? bit_3pair : bit_3slice) : ~slice_val[16];

  always_ff @(posedge core_clk) begin
    if (srst) begin
      filt1_q <= 16'sh0000;
      filt2_q <= 16'sh0000;
      env_q <= 16'sh0000;
      prev_slice_q <= 17'sh00000;
    end else begin
      filt1_q <= filt1_q + prod1[25:10];
      filt2_q <= filt2_q + prod2[25:10];
      env_q <= env_q + {{5{env_diff[16]}}, env_diff[16:6]};
      prev_slice_q <= slice_val;
    end
  end

  // Clock recovery at 32 phases per bit.
  wire cdr_tick = cdr_cnt_q + 8'h01 >= cdr_divider;
  wire edge_seen = rx_bit != last_bit_q;
  wire [4:0] phase_step = !edge_seen ? 5'h01 : (phase_q[4] ? 5'h02 : 5'h00);
  wire [4:0] phase_d = phase_q + phase_step;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cdr_cnt_q <= 8'h00;
      phase_q <= 5'h00;
      last_bit_q <= 1'b0;
      sample_q <= 1'b0;
      sdata_q <= 1'b0;
      sclk_q <= 1'b0;
    end else begin
      cdr_cnt_q <= cdr_tick ? 8'h00 : cdr_cnt_q + 8'h01;
      if (cdr_tick) begin
        phase_q <= phase_d;
        last_bit_q <= rx_bit;
        if (phase_q == 5'h10) sample_q <= rx_bit;
        if (phase_d < phase_q) sdata_q <= sample_q;
      end
      sclk_q <= phase_q[4];
    end
  end

  assign serial_data_pin = sdata_q;
  assign serial_clock_pin = sclk_q;

  // Checks. The offset period is judged only after two rises under one divisor select.
  logic [5:0] off_per_q;
  logic off_prev_q;
  logic [1:0] off_sel_q;
  logic [1:0] off_rises_q;
  wire off_rise = off_clk_q & ~off_prev_q;
  wire off_sel_same = off_sel_q == offset_clock_divisor;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      off_per_q <= 6'h00;
      off_prev_q <= 1'b0;
      off_sel_q <= 2'h0;
      off_rises_q <= 2'h0;
    end else begin
      off_per_q <= off_rise ? 6'h01 : off_per_q + 6'h01;
      off_prev_q <= off_clk_q;
      off_sel_q <= offset_clock_divisor;
      if (!off_sel_same) off_rises_q <= 2'h0;
      else if (off_rise && off_rises_q != 2'h2) off_rises_q <= off_rises_q + 2'h1;
    end
  end

  a_gain_step_down: assert property (@(posedge core_clk) disable iff (srst)
    (state_q == rad_pkg::RAD_EVAL && agc_en && above && gain_idx_q < 3'h4) |=> gain_idx_q == $past(gain_idx_q) + 3'h1)
    else $error("Gain did not step down above upper limit.");
  a_gain_step_up: assert property (@(posedge core_clk) disable iff (srst)
    (state_q == rad_pkg::RAD_EVAL && agc_en && below && gain_idx_q > 3'h0) |=> gain_idx_q == $past(gain_idx_q) - 3'h1)
    else $error("Gain did not step up below lower limit.");
  a_limit_defaults: assert property (@(posedge core_clk)
    $past(srst) |-> lower_limit == 7'd30 && upper_limit == 7'd70)
    else $error("Limits not at defaults after reset.");
  a_settle_after: assert property (@(posedge core_clk) disable iff (srst)
    $changed(gain_idx_q) |-> state_q == rad_pkg::RAD_SETTLE ##1 (!$changed(gain_idx_q) throughout !step_done[*1]))
    else $error("Gain changed without settling.");
  a_gain_hold_band: assert property (@(posedge core_clk) disable iff (srst)
    (!above && !below) |=> $stable(gain_idx_q))
    else $error("Gain changed inside limit band.");
  a_gain_saturate: assert property (@(posedge core_clk) disable iff (srst)
    gain_idx_q <= 3'h4)
    else $error("Gain index beyond five settings.");
  a_fixed_filter_gain: assert property (@(posedge core_clk) disable iff (srst)
    (!agc_en ##1 !agc_en && $stable(ctrl_q)) |-> filter_gain == fixed_filt_gain)
    else $error("Fixed filter gain not applied.");
  a_offset_period: assert property (@(posedge core_clk) disable iff (srst)
    (off_rise && off_sel_same && off_rises_q == 2'h2) |-> off_per_q == (6'h04 << offset_clock_divisor))
    else $error("Offset clock period wrong.");
  a_readback_strength: assert property (@(posedge core_clk) disable iff (srst)
    !$past(srst) |-> status_word[7:1] == $past(strength_code))
    else $error("Strength code not in readback bits.");
  a_cdr_clock_phase: assert property (@(posedge core_clk) disable iff (srst)
    serial_clock_pin == $past(phase_q[4]))
    else $error("Serial clock not following recovery phase.");
endmodule : rad_rx_ctrl

`default_nettype wire

/* test/rad_host_model.sv */
/*
 Host side model that takes the retimed serial data at each rising serial clock.
 Assumes the data pin is stable across the rising edge of the serial clock.
*/
`timescale 1ns/100ps
`default_nettype none

module rad_host_model (
  input wire logic serial_clock_pin,
  input wire logic serial_data_pin,
  output logic [15:0] bit_count,
  output logic last_bit
);
  initial begin
    bit_count = 16'h0000;
    last_bit = 1'b0;
  end

  // Takes one bit on each rising serial clock, where the data is stable.
  always @(posedge serial_clock_pin) begin
    bit_count <= bit_count + 16'h0001;
    last_bit <= serial_data_pin;
  end
endmodule : rad_host_model

`default_nettype wire

/* test/testbench.sv */
/*
 Self-checking testbench of the receive gain and demodulation control.
 Assumes one AHB-Lite master, a 100 MHz clock and a fixed random seed.
*/
`timescale 1ns/100ps
`default_nettype none
`include "rad_consts.svh"

module testbench;
  logic core_clk, srst, hsel, hwrite, hready, hreadyout, hresp, b1;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, front_amp_gain, filter_gain, ag, fg;
  logic [2:0] hsize;
  logic [6:0] strength_code, lo, up;
  logic [7:0] corr_mag_low, corr_mag_high, disc_freq;
  logic front_amp_mode, mixer_linearity, linear_path_en, offset_correction_clock;
  logic serial_data_pin, serial_clock_pin, last_bit;
  logic [15:0] bit_count, nb;
  int n_fail, n_compared, step, i;
  int cyc = 0;

  assign hready = hreadyout;

  rad_rx_ctrl i_dut (.core_clk(core_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .strength_code(strength_code), .corr_mag_low(corr_mag_low),
    .corr_mag_high(corr_mag_high), .disc_freq(disc_freq), .front_amp_gain(front_amp_gain),
    .filter_gain(filter_gain), .front_amp_mode(front_amp_mode), .mixer_linearity(mixer_linearity),
    .linear_path_en(linear_path_en), .offset_correction_clock(offset_correction_clock),
    .serial_data_pin(serial_data_pin), .serial_clock_pin(serial_clock_pin));

  rad_host_model i_host (.serial_clock_pin(serial_clock_pin), .serial_data_pin(serial_data_pin),
    .bit_count(bit_count), .last_bit(last_bit));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_fail++;
      summarize();
    end
  end

  task automatic summarize;
    if (n_fail == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    rd = hrdata;
    chk("hresp", 32'h0, 32'(hresp));
  endtask : ahb

  function automatic logic [3:0] gexp(input int k);
    case (k)
      0: return 4'hA;
      1: return 4'h6;
      2: return 4'h5;
      3: return 4'h4;
      4: return 4'h0;
      default: return 4'hF;
    endcase
  endfunction : gexp

  function automatic logic [7:0] gcorr(input logic [3:0] g);
    case (g)
      4'hA: return 8'h00;
      4'h6: return 8'h18;
      4'h5: return 8'h26;
      4'h4: return 8'h3A;
      4'h0: return 8'h56;
      default: return 8'hFF;
    endcase
  endfunction : gcorr

  task automatic walk(input int dir);
    int k, t, last;
    logic [3:0] g;
    k = dir > 0 ? 0 : 4;
    last = -step;
    for (t = 0; t < 600; t++) begin
      @(posedge core_clk);
      g = {front_amp_gain, filter_gain};
      if (g !== gexp(k)) begin
        k = k + dir;
        chk("gain step", 32'(gexp(k)), 32'(g));
        chk("settle gap", 32'h1, 32'((t - last) >= step));
        last = t;
      end
    end
    chk("gain saturated", 32'(gexp(dir > 0 ? 4 : 0)), 32'(g));
  endtask : walk

  task automatic stat_chk(input logic [3:0] g);
    ahb(1'b0, `RAD_OFF_STATUS, 32'h0);
    chk("status strength", 32'(strength_code), 32'(rd[7:1]));
    chk("status gains", 32'(g), 32'(rd[11:8]));
    chk("gain setting", 32'h1, 32'(gcorr(rd[11:8]) != 8'hFF));
  endtask : stat_chk

  task automatic hold(input logic [6:0] s);
    logic [3:0] g;
    strength_code <= s;
    repeat (3) @(posedge core_clk);
    g = {front_amp_gain, filter_gain};
    repeat (4 * step) @(posedge core_clk);
    chk("gain hold", 32'(g), 32'({front_amp_gain, filter_gain}));
  endtask : hold

  task automatic operiod(input logic [1:0] sel);
    int t0;
    ahb(1'b1, `RAD_OFF_CLKDIV, 32'h0C080000 | (32'(sel) << 4));
    repeat (70) @(posedge core_clk);
    while (offset_correction_clock !== 1'b0) @(posedge core_clk);
    while (offset_correction_clock !== 1'b1) @(posedge core_clk);
    t0 = cyc;
    @(posedge core_clk);
    while (offset_correction_clock !== 1'b0) @(posedge core_clk);
    while (offset_correction_clock !== 1'b1) @(posedge core_clk);
    chk("offset period", 32'h4 << sel, 32'(cyc - t0));
  endtask : operiod

  initial begin
    srst = 1'b1;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    strength_code = 7'h32;
    {corr_mag_low, corr_mag_high, disc_freq} = '0;
    {n_fail, n_compared} = '0;
    step = 6;
    i = $urandom(91544);
    repeat (12) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    chk("reset gains", 32'hA, 32'({front_amp_gain, filter_gain}));
    chk("reset modes", 32'h0, 32'({front_amp_mode, mixer_linearity}));
    ahb(1'b0, `RAD_OFF_CTRL, 32'h0);
    chk("ctrl reset", `RAD_CTRL_RESET, rd);
    ahb(1'b0, `RAD_OFF_LIMIT, 32'h0);
    chk("lower default", 32'h1E, 32'(rd[10:4]));
    chk("upper default", 32'h46, 32'(rd[17:11]));
    ahb(1'b1, 8'h20, 32'hFFFFFFFF);
    ahb(1'b0, 8'h20, 32'h0);
    chk("unmapped read", 32'h0, rd);
    ahb(1'b0, `RAD_OFF_CLKDIV, 32'h0);
    chk("clkdiv reset", `RAD_CLKDIV_RESET, rd);
    lo = 7'(10 + $urandom % 20);
    up = 7'(lo + 31 + $urandom % 20);
    ahb(1'b1, `RAD_OFF_LIMIT, {14'h0, up, lo, 4'h0});
    ahb(1'b1, `RAD_OFF_CLKDIV, 32'h0C080010);
    strength_code <= 7'(up + 1 + $urandom % 20);
    walk(1);
    stat_chk(4'h0);
    hold(up);
    hold(lo);
    hold(7'(lo + $urandom % (up - lo)));
    strength_code <= 7'($urandom % lo);
    walk(-1);
    stat_chk(4'hA);
    strength_code <= 7'h7F;
    for (i = 0; i < 3; i++) begin
      b1 = 1'($urandom);
      ag = 2'(2 - i);
      fg = 2'(2 - $urandom % 3);
      ahb(1'b1, `RAD_OFF_CTRL, (32'(b1) << 28) | (32'(i > 0) << 25) | (32'(fg) << 22) | (32'(ag) << 20) | 32'h4);
      repeat (4 * step) @(posedge core_clk);
      chk("fixed gains", 32'({ag, fg}), 32'({front_amp_gain, filter_gain}));
      chk("fixed modes", 32'({i > 0, b1}), 32'({front_amp_mode, mixer_linearity}));
    end
    for (i = 0; i < 3; i++) begin
      ahb(1'b1, `RAD_OFF_CTRL, i == 0 ? 32'h00E00001 : 32'h00E00005 | (32'(i == 2) << 1));
      repeat (3) @(posedge core_clk);
      chk("linear path", 32'(i != 1), 32'(linear_path_en));
    end
    for (i = 0; i < 4; i++) begin
      operiod(2'(i));
    end
    ahb(1'b1, `RAD_OFF_CTRL, `RAD_CTRL_RESET);
    for (i = 0; i < 2; i++) begin
      corr_mag_high <= i ? 8'h0A : 8'(150 + $urandom % 100);
      corr_mag_low <= i ? 8'(150 + $urandom % 100) : 8'h0A;
      nb = bit_count;
      repeat (4000) @(posedge core_clk);
      chk("serial clock runs", 32'h1, 32'(bit_count - nb >= 16'h0014));
      if (i == 0) b1 = last_bit;
      else chk("correlator decision", 32'h1, 32'(last_bit === ~b1));
    end
    ahb(1'b1, `RAD_OFF_CTRL, 32'h00E00001);
    for (i = 0; i < 2; i++) begin
      disc_freq <= i ? 8'h9C : 8'h64;
      repeat (3000) @(posedge core_clk);
      ahb(1'b0, `RAD_OFF_FREQ, 32'h0);
      chk("frequency sign", 32'(i), 32'(rd[31]));
    end
    summarize();
  end
endmodule : testbench

`default_nettype wire
